// >>> rtl/frame_timer.sv
// 8-bit down-counting frame timer with apb register access and expiry interrupt
// assumes framing events are one-cycle pulses synchronous to pclk
//
// Chosen here: register access over APB.
`include "frame_timer_regs.svh"

module frame_timer
	import frame_timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic send_first_bit_event,
	input wire logic send_last_bit_event,
	input wire logic receive_first_bit_event,
	input wire logic receive_last_bit_event,
	output logic irq
);
	logic [7:0] count_reg;
	logic [7:0] start_value_reg;
	logic auto_reload_reg;
	logic [4:0] divider_exponent_reg;
	logic [3:0] event_select_reg;
	logic expiry_status_reg;
	logic expiry_enable_reg;
	logic [20:0] prescale_reg;
	logic ready_reg;
	logic irq_reg;
	logic [31:0] rdata_reg;
	logic err_reg;
	timer_state_type state_reg;

	logic access;
	logic wr;
	logic [5:0] index;
	logic addr_ok;
	logic sw_start;
	logic sw_halt;
	logic start_evt;
	logic stop_evt;
	logic tick;
	logic [20:0] prescale_mask;
	logic expire;
	logic [31:0] read_value;
	logic index_mapped;

	// the answer comes one cycle after setup: the access phase sees pready high
	assign access = psel && penable && ready_reg;
	assign wr = access && pwrite;
	assign index = paddr[7:2];
	assign addr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0);
	// software start and halt come from one write; start wins if both bits are set
	assign sw_start = wr && addr_ok && (index == `IDX_DEVICE_CONTROL)
		&& pwdata[`BIT_SOFTWARE_START];
	assign sw_halt = wr && addr_ok && (index == `IDX_DEVICE_CONTROL)
		&& pwdata[`BIT_SOFTWARE_HALT];
	assign start_evt = sw_start
		|| (send_first_bit_event && event_select_reg[`BIT_START_SEND_FIRST])
		|| (send_last_bit_event && event_select_reg[`BIT_START_SEND_LAST]);
	assign stop_evt = sw_halt
		|| (receive_first_bit_event && event_select_reg[`BIT_HALT_RECV_FIRST])
		|| (receive_last_bit_event && event_select_reg[`BIT_HALT_RECV_LAST]);

	// mask of low prescaler bits; tick when they are all ones
	always_comb begin
		prescale_mask = '0;
		for (int i = 0; i < 21; i++) begin
			if (i < 32'(divider_exponent_reg)) begin
				prescale_mask[i] = 1'b1;
			end
		end
	end
	assign tick = ((prescale_reg & prescale_mask) == prescale_mask);
	// an event in the expiry cycle wins: a halted or retriggered timer never expires
	assign expire = (state_reg == count_state) && tick && (count_reg == 8'h01)
		&& !start_evt && !stop_evt;

	// restarting on start makes the first tick a full period after the load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_reg <= '0;
		end else if (start_evt || state_reg == idle_state) begin
			prescale_reg <= '0;
		end else begin
			prescale_reg <= tick ? 21'h000000 : prescale_reg + 21'h000001;
		end
	end

	// the outputs of this block feed only software; framing logic is never driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= idle_state;
			count_reg <= 8'h00;
		end else if (start_evt) begin
			state_reg <= count_state;
			count_reg <= start_value_reg;
		end else if (stop_evt) begin
			state_reg <= idle_state;
		end else if (state_reg == count_state && tick) begin
			unique case (state_reg)
				idle_state: begin
					count_reg <= count_reg;
				end
				count_state: begin
					if (count_reg == 8'h01 && auto_reload_reg) begin
						count_reg <= start_value_reg;
					end else if (count_reg != 8'h00) begin
						count_reg <= count_reg - 8'h01;
					end
					if (!auto_reload_reg && count_reg <= 8'h01) begin
						state_reg <= idle_state;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_value_reg <= `RESET_START_VALUE;
			auto_reload_reg <= 1'b0;
			divider_exponent_reg <= `RESET_DIVIDER;
			event_select_reg <= `RESET_EVENT_SELECT;
			expiry_enable_reg <= 1'b0;
		end else if (wr && addr_ok) begin
			unique case (index)
				// the start value reaches the counter through a start event or an auto reload at one
				`IDX_START_VALUE: start_value_reg <= pwdata[7:0];
				`IDX_TICK_DIVIDER: begin
					auto_reload_reg <= pwdata[`BIT_AUTO_RELOAD];
					// exponents above the legal range saturate at the top
					divider_exponent_reg <= (pwdata[4:0] > `DIVIDER_EXP_MAX)
						? `DIVIDER_EXP_MAX : pwdata[4:0];
				end
				`IDX_EVENT_SELECT: event_select_reg <= pwdata[3:0];
				`IDX_IRQ_ENABLE: expiry_enable_reg <= pwdata[`BIT_EXPIRY];
				default: begin
				end
			endcase
		end
	end

	// set wins over a clear written in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expiry_status_reg <= 1'b0;
		end else if (expire) begin
			expiry_status_reg <= 1'b1;
		end else if (wr && addr_ok && index == `IDX_IRQ_CLEAR && pwdata[`BIT_EXPIRY]) begin
			expiry_status_reg <= 1'b0;
		end
	end

	// registered so irq leaves a flip-flop; it rises with the status and falls one cycle after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (expiry_status_reg || expire) && expiry_enable_reg;
		end
	end

	// indices that answer without an error
	always_comb begin
		index_mapped = 1'b0;
		unique case (index)
			`IDX_SECONDARY_STATUS,
			`IDX_DEVICE_CONTROL,
			`IDX_COUNT_VALUE,
			`IDX_TICK_DIVIDER,
			`IDX_EVENT_SELECT,
			`IDX_START_VALUE,
			`IDX_IRQ_STATUS,
			`IDX_IRQ_ENABLE,
			`IDX_IRQ_CLEAR: index_mapped = 1'b1;
			default: index_mapped = 1'b0;
		endcase
	end

	// write-only and unmapped indices read as zero
	always_comb begin
		read_value = 32'h00000000;
		unique case (index)
			`IDX_SECONDARY_STATUS: read_value[`BIT_COUNTING_FLAG] = (state_reg == count_state);
			`IDX_COUNT_VALUE: read_value[7:0] = count_reg;
			`IDX_TICK_DIVIDER: read_value[5:0] = {auto_reload_reg, divider_exponent_reg};
			`IDX_EVENT_SELECT: read_value[3:0] = event_select_reg;
			`IDX_START_VALUE: read_value[7:0] = start_value_reg;
			`IDX_IRQ_STATUS: read_value[`BIT_EXPIRY] = expiry_status_reg;
			`IDX_IRQ_ENABLE: read_value[`BIT_EXPIRY] = expiry_enable_reg;
			default: read_value = 32'h00000000;
		endcase
	end

	// zero wait states: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
		end else begin
			ready_reg <= psel && !penable;
			err_reg <= psel && !penable && !(addr_ok && index_mapped);
			rdata_reg <= (psel && !penable && !pwrite && addr_ok) ? read_value : 32'h00000000;
		end
	end

	assign prdata = rdata_reg;
	assign pready = ready_reg;
	assign pslverr = err_reg;
	assign irq = irq_reg;

	// checks of the counter, the prescaler, the flags and the read path
	a_decrement_step: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == count_state && tick && !start_evt && !stop_evt
		&& count_reg > 8'h01 |=> count_reg == $past(count_reg) - 8'h01)
		else $error("count did not step down by one");

	a_reload_at_one: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == count_state && tick && auto_reload_reg && count_reg == 8'h01
		&& !start_evt && !stop_evt
		|=> count_reg == $past(start_value_reg) && state_reg == count_state)
		else $error("auto reload missed");

	a_start_loads: assert property (@(posedge pclk) disable iff (!presetn)
		start_evt |=> count_reg == $past(start_value_reg)
		&& state_reg == count_state && prescale_reg == 21'h000000)
		else $error("start event did not reload");

	a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
		stop_evt && !start_evt |=> state_reg == idle_state
		&& $stable(count_reg))
		else $error("stop event did not halt");

	a_stop_at_zero: assert property (@(posedge pclk) disable iff (!presetn)
		expire && !auto_reload_reg |=> state_reg == idle_state
		&& count_reg == 8'h00 && expiry_status_reg)
		else $error("one-shot did not stop at zero");

	a_halt_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
		sw_halt && !start_evt && !expiry_status_reg
		|=> !expiry_status_reg)
		else $error("software halt raised expiry");

	a_value_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!start_evt && !(state_reg == count_state && tick)
		|=> $stable(count_reg))
		else $error("count changed without tick or start");

	a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
		expire && expiry_enable_reg ##1 expiry_enable_reg
		|=> irq)
		else $error("interrupt not raised after expiry");

	a_prescale_count: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == count_state && !tick && !start_evt
		|=> prescale_reg == $past(prescale_reg) + 21'h000001)
		else $error("prescaler did not advance");

	a_prescale_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == count_state && tick
		|=> prescale_reg == 21'h000000)
		else $error("prescaler did not wrap at tick");

	a_prescale_idle: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == idle_state
		|=> prescale_reg == 21'h000000)
		else $error("prescaler ran while idle");

	a_exponent_range: assert property (@(posedge pclk) disable iff (!presetn)
		divider_exponent_reg <= `DIVIDER_EXP_MAX)
		else $error("divider exponent above range");

	a_start_wins: assert property (@(posedge pclk) disable iff (!presetn)
		start_evt && stop_evt |=> state_reg == count_state
		&& count_reg == $past(start_value_reg))
		else $error("stop won over start");

	a_retrigger: assert property (@(posedge pclk) disable iff (!presetn)
		start_evt && state_reg == count_state
		|=> count_reg == $past(start_value_reg) && prescale_reg == 21'h000000)
		else $error("retrigger did not reload");

	a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && addr_ok && index == `IDX_SECONDARY_STATUS
		|=> prdata == {24'h000000, $past(state_reg == count_state), 7'h00})
		else $error("counting flag read wrong");

	a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && addr_ok && index == `IDX_COUNT_VALUE
		|=> prdata == {24'h000000, $past(count_reg)})
		else $error("count value read wrong");

	a_expiry_sets: assert property (@(posedge pclk) disable iff (!presetn)
		expire
		|=> expiry_status_reg)
		else $error("expiry flag not set");

	a_periodic_runs: assert property (@(posedge pclk) disable iff (!presetn)
		expire && auto_reload_reg
		|=> state_reg == count_state && expiry_status_reg)
		else $error("periodic timer stopped at expiry");

	a_irq_enable: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> $past(expiry_enable_reg))
		else $error("interrupt raised while disabled");

	a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
		!expiry_status_reg && !expire
		|=> !irq)
		else $error("interrupt without expiry");

	a_idle_stays: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == idle_state && !start_evt
		|=> state_reg == idle_state)
		else $error("timer started without start event");

	a_reload_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && addr_ok && index == `IDX_START_VALUE
		|=> start_value_reg == $past(pwdata[7:0]))
		else $error("start value write lost");

	a_stop_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		stop_evt && !start_evt && !expiry_status_reg
		|=> !expiry_status_reg)
		else $error("stop event raised expiry");

	a_clear_status: assert property (@(posedge pclk) disable iff (!presetn)
		wr && addr_ok && index == `IDX_IRQ_CLEAR && pwdata[`BIT_EXPIRY] && !expire
		|=> !expiry_status_reg)
		else $error("expiry flag not cleared");

	a_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
		expiry_status_reg && !(wr && addr_ok && index == `IDX_IRQ_CLEAR)
		|=> expiry_status_reg)
		else $error("expiry flag dropped by itself");

	c_one_shot: cover property (@(posedge pclk) disable iff (!presetn)
		expire && !auto_reload_reg);

	c_periodic: cover property (@(posedge pclk) disable iff (!presetn)
		expire && auto_reload_reg ##[1:300] expire);

	c_retrigger: cover property (@(posedge pclk) disable iff (!presetn)
		start_evt && state_reg == count_state);

	c_start_stop: cover property (@(posedge pclk) disable iff (!presetn)
		start_evt && stop_evt);

	c_event_start: cover property (@(posedge pclk) disable iff (!presetn)
		send_first_bit_event && event_select_reg[`BIT_START_SEND_FIRST]);
endmodule

// >>> rtl/frame_timer_regs.svh
// register map, field positions and reset values of the frame timer
// assumes apb byte addresses equal to four times the printed register index
`ifndef FRAME_TIMER_REGS_SVH
`define FRAME_TIMER_REGS_SVH
`define IDX_SECONDARY_STATUS 6'h05
`define IDX_DEVICE_CONTROL 6'h09
`define IDX_COUNT_VALUE 6'h0c
`define IDX_TICK_DIVIDER 6'h2a
`define IDX_EVENT_SELECT 6'h2b
`define IDX_START_VALUE 6'h2c
`define IDX_IRQ_STATUS 6'h30
`define IDX_IRQ_ENABLE 6'h31
`define IDX_IRQ_CLEAR 6'h32
`define BIT_COUNTING_FLAG 7
`define BIT_SOFTWARE_START 1
`define BIT_SOFTWARE_HALT 2
`define BIT_AUTO_RELOAD 5
`define BIT_START_SEND_FIRST 0
`define BIT_START_SEND_LAST 1
`define BIT_HALT_RECV_FIRST 2
`define BIT_HALT_RECV_LAST 3
`define BIT_EXPIRY 0
`define DIVIDER_EXP_MAX 5'h15
`define RESET_DIVIDER 5'h00
`define RESET_EVENT_SELECT 4'h0
`define RESET_START_VALUE 8'h00
`endif

// >>> rtl/frame_timer_pkg.sv
// types shared by the frame timer
// assumes nothing beyond a systemverilog tool
package frame_timer_pkg;
	typedef enum logic [0:0] {
		idle_state = 1'b0,
		count_state = 1'b1
	} timer_state_type;
endpackage

// >>> dv/frame_events_model.sv
// framing logic stand-in: one-cycle event pulses on request
// assumes fire is raised for one cycle by the bench
module frame_events_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fire,
	input wire logic [3:0] which,
	output logic send_first_bit_event,
	output logic send_last_bit_event,
	output logic receive_first_bit_event,
	output logic receive_last_bit_event
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pulse_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse_reg <= 4'h0;
		else
			pulse_reg <= fire ? which : 4'h0;
	end
	assign {receive_last_bit_event, receive_first_bit_event} = pulse_reg[3:2];
	assign {send_last_bit_event, send_first_bit_event} = pulse_reg[1:0];
endmodule

// >>> dv/contactless_frame_timer_tb.sv
// self-checking bench of the frame timer over apb
// assumes one clock, events from the framing model
`include "frame_timer_regs.svh"
module contactless_frame_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, a;
	logic [3:0] which = 4'h0;
	logic pready, pslverr, irq, slv, sf, sl, rf, rl;
	int errors = 0, compares = 0, n;
	int rows [5][3] = '{'{0, 1, 1}, '{0, 5, 5}, '{2, 3, 12}, '{3, 2, 16}, '{1, 255, 510}};
	int evt [6][2] = '{'{2, 0}, '{1, 128}, '{8, 128}, '{4, 0}, '{6, 128}, '{8, 0}};
	always #5 pclk = ~pclk;
	frame_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .send_first_bit_event(sf),
		.send_last_bit_event(sl), .receive_first_bit_event(rf),
		.receive_last_bit_event(rl), .irq(irq));
	frame_events_model fem (.pclk(pclk), .presetn(presetn), .fire(fire), .which(which),
		.send_first_bit_event(sf), .send_last_bit_event(sl),
		.receive_first_bit_event(rf), .receive_last_bit_event(rl));
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(logic w, logic [5:0] idx, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// counts edges from the edge after the start write completes up to irq seen high
	task automatic wait_irq(int limit);
		n = 0;
		while (irq !== 1'b1 && n < limit) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic ev(logic [3:0] w);
		fire <= 1'b1;
		which <= w;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (evt[i]) begin
			apb(1'b0, i == 0 ? `IDX_START_VALUE : i == 1 ? `IDX_TICK_DIVIDER :
				i == 2 ? `IDX_EVENT_SELECT : i == 3 ? `IDX_SECONDARY_STATUS :
				i == 4 ? `IDX_COUNT_VALUE : `IDX_IRQ_STATUS, 32'h0);
			check(rd, 32'h0);
		end
		apb(1'b0, 6'h3f, 32'h0);
		check({rd[30:0], slv}, 32'h1);
		apb(1'b1, `IDX_IRQ_ENABLE, 32'h1);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'b1, `IDX_TICK_DIVIDER, rows[i][0]);
			apb(1'b1, `IDX_START_VALUE, rows[i][1]);
			apb(1'b1, `IDX_DEVICE_CONTROL, 32'h2);
			wait_irq(600);
			check(n, rows[i][2]);
			apb(1'b0, `IDX_COUNT_VALUE, 32'h0);
			check(rd, 32'h0);
			apb(1'b0, `IDX_SECONDARY_STATUS, 32'h0);
			check(rd, 32'h0);
			apb(1'b1, `IDX_IRQ_CLEAR, 32'h1);
			apb(1'b0, `IDX_IRQ_STATUS, 32'h0);
			check({rd[30:0], irq}, 32'h0);
			$display("row %0d done", i);
		end
		apb(1'b1, `IDX_TICK_DIVIDER, 32'h0);
		apb(1'b1, `IDX_START_VALUE, 32'hc8);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h2);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h4);
		apb(1'b0, `IDX_COUNT_VALUE, 32'h0);
		a = rd;
		apb(1'b0, `IDX_COUNT_VALUE, 32'h0);
		check(rd, a);
		apb(1'b0, `IDX_IRQ_STATUS, 32'h0);
		check({rd[7:0], a[7:4] != 4'h0}, 9'h1);
		$display("halt test done");
		apb(1'b1, `IDX_TICK_DIVIDER, 32'h2);
		apb(1'b1, `IDX_START_VALUE, 32'h0a);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h2);
		apb(1'b1, `IDX_START_VALUE, 32'h32);
		apb(1'b0, `IDX_COUNT_VALUE, 32'h0);
		check(rd <= 32'ha, 1'b1);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h2);
		wait_irq(600);
		check(n, 200);
		apb(1'b1, `IDX_IRQ_CLEAR, 32'h1);
		$display("retrigger test done");
		apb(1'b1, `IDX_TICK_DIVIDER, 32'h20);
		apb(1'b1, `IDX_START_VALUE, 32'h14);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h2);
		wait_irq(100);
		check(n, 20);
		apb(1'b1, `IDX_IRQ_CLEAR, 32'h1);
		apb(1'b0, `IDX_SECONDARY_STATUS, 32'h0);
		check(rd, 32'h80);
		wait_irq(40);
		check(irq, 1'b1);
		check(n, 14);
		apb(1'b1, `IDX_DEVICE_CONTROL, 32'h4);
		apb(1'b1, `IDX_IRQ_CLEAR, 32'h1);
		apb(1'b1, `IDX_TICK_DIVIDER, 32'h0);
		$display("periodic test done");
		apb(1'b1, `IDX_EVENT_SELECT, 32'h5);
		foreach (evt[i]) begin
			if (i == 4)
				apb(1'b1, `IDX_EVENT_SELECT, 32'hf);
			ev(evt[i][0]);
			apb(1'b0, `IDX_SECONDARY_STATUS, 32'h0);
			check(rd, evt[i][1]);
		end
		$display("event test done");
		report_and_stop();
	end
endmodule
